// ---- cam_track_signal_path.sv ----
// Cam track signal path: flags, special tracks, enables, gating, APB registers
// Function
// - Cam flags and track results from position
// - Counter mode combines tracks 0/1 result
// - Brake mode combines track 2 with input
// - Direct-set selects enable word as signals
// - Host enables tracks and starts counters
// - Optional AND of track 3 with gate
// - Host reads uncombined flag bits on request
// - Tracks 3..31 flag equals track result
// - Final tracks 0..12 reported and driven
// - Tracks 13..31 reported unchanged
// - Counter decrements on rise, reload on fall after zero
// - Brake flag set on rise, staged clear
// - Track result is OR of cams
`default_nettype none
module cam_track_signal_path
  import cam_track_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [POS_W-1:0] actual_position,
  input wire logic brake_enable_input,
  input wire logic track3_gate_input,
  output logic [NUM_OUT-1:0] track_output_pins,
  output logic [NUM_TRACKS-1:0] track_signals
);
  // Whole state of the block
  typedef struct packed {
    ctrl_t ctrl;                          // Configuration
    logic [NUM_OUT-1:0] track_en;         // Track output enable word
    logic [1:0][CNT_W-1:0] preset;        // Counter presets
    cam_cfg_t [NUM_CAMS-1:0] cams;        // Cam table
    logic brake_meta;                     // Synchroniser stage one
    logic brake_sync;                     // Synchroniser stage two
    logic gate_meta;                      // Synchroniser stage one
    logic gate_sync;                      // Synchroniser stage two
    logic brake_prev;                     // Brake input last cycle
    logic [2:0] res_prev;                 // Results of tracks 0..2 last cycle
    logic [1:0][CNT_W-1:0] cnt;           // Counter values
    logic [1:0] cnt_flag;                 // Counter track flags
    logic brake_flag;                     // Brake track flag
    logic brake_dropped;                  // Brake input seen low since set
    logic [NUM_TRACKS-1:0] flag_snap;     // Readout of flag bits
    logic [NUM_CAMS-1:0] cam_snap;        // Readout of cam flags
    logic [POS_W-1:0] pos_snap;           // Readout of position
    logic [NUM_TRACKS-1:0] track_sig;     // Final track signals
    logic [NUM_OUT-1:0] pins;             // Output pins
    logic [31:0] rdata;                   // APB read data
    logic slverr;                         // APB error answer
  } state_t;

  state_t q, d;
  logic [NUM_CAMS-1:0] cam_flags;      // Live cam flags
  logic [NUM_TRACKS-1:0] track_results; // Live track results
  logic [NUM_TRACKS-1:0] flag_bits;    // Flags before combination
  logic [NUM_OUT-1:0] low_sig;         // Combined tracks 0..12
  logic setup_ph;                      // APB setup cycle
  logic access_wr;                     // APB write taking effect
  logic [2:0] cam_idx;                 // Cam word index
  logic in_cam;                        // Address hits cam table
  logic brake_rise;                    // Rising edge of brake input

  // Cam comparison and per-track OR
  cam_track_eval u_eval (
    .position(actual_position),
    .cams(q.cams),
    .cam_flags(cam_flags),
    .track_results(track_results)
  );

  // Bus phase decode
  assign setup_ph = psel && !penable;
  assign access_wr = psel && penable && pwrite;
  assign cam_idx = paddr[4:2];
  assign in_cam = (paddr >= OFF_CAM_BASE) && (paddr <= OFF_CAM_LAST) && (paddr[1:0] == 2'h0);
  assign brake_rise = q.brake_sync && !q.brake_prev;

  // Flag bits ahead of configuration and enables
  always_comb
  begin
    flag_bits = track_results;
    // Counter tracks take the counter flag
    flag_bits[TRK_CNT_A] = q.ctrl.cnt_mode_a ? q.cnt_flag[0] : track_results[TRK_CNT_A];
    flag_bits[TRK_CNT_B] = q.ctrl.cnt_mode_b ? q.cnt_flag[1] : track_results[TRK_CNT_B];
    // Brake track takes the brake flag
    flag_bits[TRK_BRAKE] = q.ctrl.brake_mode ? q.brake_flag : track_results[TRK_BRAKE];
  end

  // Direct set, enable masking and track 3 gating
  always_comb
  begin
    // Either the enable word itself or enabled flags
    low_sig = q.ctrl.direct_set ? q.track_en : (flag_bits[NUM_OUT-1:0] & q.track_en);
    // Optional external gate on track 3
    if (q.ctrl.track3_gate_option)
    begin
      low_sig[TRK_GATED] = low_sig[TRK_GATED] & q.gate_sync;
    end
  end

  // Next-state logic
  always_comb
  begin
    logic rise;
    logic fall;
    logic en;
    rise = 1'b0;
    fall = 1'b0;
    en = 1'b0;
    d = q;
    // Input synchronisers
    d.brake_meta = brake_enable_input;
    d.brake_sync = q.brake_meta;
    d.gate_meta = track3_gate_input;
    d.gate_sync = q.gate_meta;
    d.brake_prev = q.brake_sync;
    d.res_prev = track_results[2:0];
    // Counter tracks
    for (int i = 0; i < 2; i++)
    begin
      rise = track_results[i] && !q.res_prev[i];
      fall = !track_results[i] && q.res_prev[i];
      en = (i == 0) ? q.ctrl.counter_track_a_enable : q.ctrl.counter_track_b_enable;
      if (!en)
      begin
        // Stopped counter waits at its preset
        d.cnt[i] = q.preset[i];
        d.cnt_flag[i] = 1'b0;
      end
      else if (fall && q.cnt_flag[i])
      begin
        // Falling edge after zero clears and reloads
        d.cnt_flag[i] = 1'b0;
        d.cnt[i] = q.preset[i];
      end
      else if (rise && (q.cnt[i] != '0))
      begin
        // Count down, flag when zero reached
        d.cnt[i] = q.cnt[i] - CNT_W'(1);
        d.cnt_flag[i] = (q.cnt[i] == CNT_W'(1));
      end
    end
    // Brake track
    if (brake_rise)
    begin
      // Rising input sets the flag
      d.brake_flag = 1'b1;
      d.brake_dropped = 1'b0;
    end
    else if (q.brake_flag && !q.brake_sync && !q.brake_dropped)
    begin
      // Input released, arm the clear
      d.brake_dropped = 1'b1;
    end
    else if (q.brake_dropped && q.res_prev[TRK_BRAKE] && !track_results[TRK_BRAKE])
    begin
      // Falling result edge after release clears
      d.brake_flag = 1'b0;
      d.brake_dropped = 1'b0;
    end
    // Final signals toward host and pins
    d.track_sig = {flag_bits[NUM_TRACKS-1:NUM_OUT], low_sig};
    d.pins = low_sig;
    // APB read answer prepared in setup cycle
    if (setup_ph)
    begin
      d.rdata = 32'h0000_0000;
      d.slverr = 1'b0;
      if (in_cam)
      begin
        d.rdata = q.cams[cam_idx];
      end
      else
      begin
        unique case (paddr)
          OFF_CTRL: d.rdata = {25'h0, q.ctrl};
          OFF_TRACK_EN: d.rdata = {19'h0, q.track_en};
          OFF_PRESET_A: d.rdata = {16'h0, q.preset[0]};
          OFF_PRESET_B: d.rdata = {16'h0, q.preset[1]};
          OFF_READOUT: d.rdata = 32'h0000_0000;
          OFF_FLAG_SNAP: d.rdata = q.flag_snap;
          OFF_CAM_SNAP: d.rdata = {24'h0, q.cam_snap};
          OFF_TRACK_SIG: d.rdata = q.track_sig;
          OFF_POS_SNAP: d.rdata = {20'h0, q.pos_snap};
          default: d.slverr = 1'b1;
        endcase
      end
    end
    // APB writes at the access edge
    if (access_wr && !q.slverr)
    begin
      if (in_cam)
      begin
        d.cams[cam_idx] = cam_cfg_t'(pwdata & 32'h9fff_ffff);
      end
      else
      begin
        unique case (paddr)
          OFF_CTRL: d.ctrl = ctrl_t'(pwdata[CTRL_W-1:0]);
          OFF_TRACK_EN: d.track_en = pwdata[NUM_OUT-1:0];
          OFF_PRESET_A: d.preset[0] = pwdata[CNT_W-1:0];
          OFF_PRESET_B: d.preset[1] = pwdata[CNT_W-1:0];
          OFF_READOUT:
          begin
            // Either request freezes the raw flag bits
            if (pwdata[RD_POS_BIT] || pwdata[RD_CAM_BIT])
            begin
              d.flag_snap = flag_bits;
            end
            if (pwdata[RD_POS_BIT])
            begin
              d.pos_snap = actual_position;
            end
            if (pwdata[RD_CAM_BIT])
            begin
              d.cam_snap = cam_flags;
            end
          end
          default: d.slverr = q.slverr;
        endcase
      end
    end
  end

  // State register with synchronous reset
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      // Everything cleared, counters at reset preset
      q <= '0;
      q.ctrl <= CTRL_RST;
      q.track_en <= TRACK_EN_RST;
      q.preset <= {PRESET_RST, PRESET_RST};
      q.cnt <= {PRESET_RST, PRESET_RST};
    end
    else
    begin
      q <= d;
    end
  end

  // Outputs from registers, bus handshake from psel and penable
  assign prdata = q.rdata;
  assign pslverr = q.slverr && psel && penable;
  assign pready = psel && penable;
  assign track_output_pins = q.pins;
  assign track_signals = q.track_sig;

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // Readout write sequence
  sequence s_readout_wr;
    access_wr && !q.slverr && (paddr == OFF_READOUT) && (pwdata[RD_POS_BIT] || pwdata[RD_CAM_BIT]);
  endsequence
  // Counter step sequence
  sequence s_cnt_step;
    q.ctrl.counter_track_a_enable && track_results[0] && !q.res_prev[0] && (q.cnt[0] != '0);
  endsequence
  // Brake arm sequence
  sequence s_brake_arm;
    q.brake_flag && !q.brake_dropped && !q.brake_sync ##1 q.brake_dropped;
  endsequence
  // Last counter step sequence
  sequence s_cnt_last;
    q.ctrl.counter_track_a_enable && track_results[0] && !q.res_prev[0] && (q.cnt[0] == CNT_W'(1));
  endsequence
  // Counter release sequence
  sequence s_cnt_release;
    q.ctrl.counter_track_a_enable && q.cnt_flag[0] && q.res_prev[0] && !track_results[0];
  endsequence
  // Brake release sequence
  sequence s_brake_release;
    q.brake_dropped && q.res_prev[TRK_BRAKE] && !track_results[TRK_BRAKE] && !brake_rise;
  endsequence

  // Output stage checks
  a_direct_pass: assert property (!$past(rst) && $past(q.ctrl.direct_set) |->
      (q.pins[12:4] == $past(q.track_en[12:4]))) else $error("direct set mismatch");
  a_enable_mask: assert property (!$past(rst) && !$past(q.ctrl.direct_set) |->
      ((q.pins & ~$past(q.track_en)) == '0)) else $error("disabled track driven");
  a_gate_and: assert property (!$past(rst) && $past(q.ctrl.track3_gate_option) &&
      !$past(q.gate_sync) |-> !q.pins[TRK_GATED]) else $error("track 3 not gated");
  a_gate_off: assert property (!$past(rst) && !$past(q.ctrl.track3_gate_option) &&
      !$past(q.ctrl.direct_set) |->
      (q.pins[TRK_GATED] == ($past(flag_bits[TRK_GATED]) && $past(q.track_en[TRK_GATED]))))
      else $error("track 3 gated without option");
  a_direct_gate: assert property (!$past(rst) && $past(q.ctrl.direct_set) &&
      $past(q.ctrl.track3_gate_option) |->
      (q.pins[TRK_GATED] == ($past(q.track_en[TRK_GATED]) && $past(q.gate_sync))))
      else $error("direct track 3 not gated");
  a_upper_pass: assert property (!$past(rst) |->
      (q.track_sig[31:13] == $past(track_results[31:13]))) else $error("upper track altered");
  a_pins_report: assert property (track_output_pins == track_signals[NUM_OUT-1:0])
      else $error("pins differ from report");

  // Readout checks
  a_snap_take: assert property (s_readout_wr |=> (q.flag_snap == $past(flag_bits)))
      else $error("readout snapshot wrong");
  a_pos_snap: assert property (s_readout_wr ##0 pwdata[RD_POS_BIT] |=>
      (q.pos_snap == $past(actual_position))) else $error("position snapshot wrong");
  a_cam_snap: assert property (s_readout_wr ##0 pwdata[RD_CAM_BIT] |=>
      (q.cam_snap == $past(cam_flags))) else $error("cam snapshot wrong");

  // Counter track checks
  a_cnt_mode: assert property (q.ctrl.cnt_mode_a |-> (flag_bits[0] == q.cnt_flag[0]))
      else $error("counter flag not used");
  a_cnt_mode_b: assert property (q.ctrl.cnt_mode_b |-> (flag_bits[1] == q.cnt_flag[1]))
      else $error("second counter flag not used");
  a_cnt_plain: assert property (!q.ctrl.cnt_mode_a |-> (flag_bits[0] == track_results[0]))
      else $error("plain track 0 altered");
  a_cnt_dec: assert property (s_cnt_step |=> (q.cnt[0] == $past(q.cnt[0]) - CNT_W'(1)))
      else $error("counter did not step");
  a_cnt_zero: assert property (s_cnt_last |=> q.cnt_flag[0])
      else $error("counter flag not set at zero");
  a_cnt_reload: assert property (s_cnt_release |=> !q.cnt_flag[0] && (q.cnt[0] == $past(q.preset[0])))
      else $error("counter not reloaded");
  a_cnt_stop: assert property (!q.ctrl.counter_track_b_enable |=>
      !q.cnt_flag[1] && (q.cnt[1] == $past(q.preset[1]))) else $error("stopped counter moved");

  // Brake track checks
  a_brake_mode: assert property (!q.ctrl.brake_mode |-> (flag_bits[2] == track_results[2]))
      else $error("brake flag leaked");
  a_brake_use: assert property (q.ctrl.brake_mode |-> (flag_bits[TRK_BRAKE] == q.brake_flag))
      else $error("brake flag not used");
  a_brake_set: assert property (brake_rise |=> q.brake_flag)
      else $error("brake flag not set");
  a_brake_hold: assert property (s_brake_arm |-> q.brake_flag)
      else $error("brake flag not held");
  a_brake_clear: assert property (s_brake_release |=> !q.brake_flag)
      else $error("brake flag not cleared");

  // Track result and reset checks
  a_cam_or: assert property (cam_flags[0] |-> track_results[q.cams[0].track])
      else $error("active cam lost");
  a_reset_clear: assert property (@(posedge sys_clk) disable iff (1'b0)
      rst |=> (q.pins == '0) && !q.brake_flag && (q.cnt_flag == '0)) else $error("reset did not clear");
endmodule // cam_track_signal_path
`default_nettype wire

// ---- cam_track_pkg.sv ----
// Constants, register map and carrier types for the cam track signal path
`default_nettype none
package cam_track_pkg;
  // Sizes of the path
  localparam int NUM_CAMS = 8;
  localparam int NUM_TRACKS = 32;
  localparam int NUM_OUT = 13;
  localparam int POS_W = 12;
  localparam int CNT_W = 16;
  localparam int TRK_W = 5;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_TRACK_EN = 8'h04;
  localparam logic [7:0] OFF_PRESET_A = 8'h08;
  localparam logic [7:0] OFF_PRESET_B = 8'h0c;
  localparam logic [7:0] OFF_READOUT = 8'h10;
  localparam logic [7:0] OFF_FLAG_SNAP = 8'h14;
  localparam logic [7:0] OFF_CAM_SNAP = 8'h18;
  localparam logic [7:0] OFF_TRACK_SIG = 8'h1c;
  localparam logic [7:0] OFF_POS_SNAP = 8'h20;
  localparam logic [7:0] OFF_CAM_BASE = 8'h40;
  localparam logic [7:0] OFF_CAM_LAST = 8'h5c;
  // Readout request bit positions
  localparam int RD_POS_BIT = 0;
  localparam int RD_CAM_BIT = 1;
  // Special track indices
  localparam int TRK_CNT_A = 0;
  localparam int TRK_CNT_B = 1;
  localparam int TRK_BRAKE = 2;
  localparam int TRK_GATED = 3;
  // Reset values
  localparam logic [CNT_W-1:0] PRESET_RST = 16'h0000;
  localparam logic [NUM_OUT-1:0] TRACK_EN_RST = 13'h0000;
  // Control word, bit 6 downward
  typedef struct packed {
    logic counter_track_b_enable;  // Bit 6
    logic counter_track_a_enable;  // Bit 5
    logic track3_gate_option;      // Bit 4
    logic brake_mode;              // Bit 3
    logic cnt_mode_b;              // Bit 2
    logic cnt_mode_a;              // Bit 1
    logic direct_set;              // Bit 0
  } ctrl_t;
  localparam int CTRL_W = $bits(ctrl_t);
  localparam ctrl_t CTRL_RST = '0;
  // One cam word: enable, track, end, start
  typedef struct packed {
    logic en;                    // Bit 31
    logic [1:0] rsvd;            // Bits 30:29, read zero
    logic [TRK_W-1:0] track;     // Bits 28:24
    logic [POS_W-1:0] end_pos;   // Bits 23:12
    logic [POS_W-1:0] start_pos; // Bits 11:0
  } cam_cfg_t;
  localparam cam_cfg_t CAM_RST = '0;
endpackage : cam_track_pkg
`default_nettype wire

// ---- cam_track_eval.sv ----
// Cam flag and track result evaluation from actual position
`default_nettype none
module cam_track_eval
  import cam_track_pkg::*;
(
  input wire logic [POS_W-1:0] position,
  input wire cam_cfg_t [NUM_CAMS-1:0] cams,
  output logic [NUM_CAMS-1:0] cam_flags,
  output logic [NUM_TRACKS-1:0] track_results
);
  // Cam is on while position lies in its closed window
  genvar c;
  generate
    for (c = 0; c < NUM_CAMS; c++)
    begin : g_cam
      assign cam_flags[c] = cams[c].en && (position >= cams[c].start_pos) && (position <= cams[c].end_pos);
    end
  endgenerate

  // Each track ORs all cams assigned to it
  genvar t;
  generate
    for (t = 0; t < NUM_TRACKS; t++)
    begin : g_track
      always_comb
      begin
        track_results[t] = 1'b0;
        for (int k = 0; k < NUM_CAMS; k++)
        begin
          // Assigned cam contributes
          if (cams[k].track == TRK_W'(t))
          begin
            track_results[t] = track_results[t] | cam_flags[k];
          end
        end
      end
    end
  endgenerate
endmodule // cam_track_eval
`default_nettype wire

// ---- apb_host_model.sv ----
// Host controller model: APB master that writes enables and reads back signals
`default_nettype none
module apb_host_model
  import cam_track_pkg::*;
(
  input wire logic sys_clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  // Bus idle from time zero
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
  end
  // One transfer: setup, access held until pready, then release; ok low on no answer
  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                      output logic [31:0] rdata, output logic err, output logic ok);
    int n;
    ok = 1'b0;
    err = 1'b0;
    rdata = 32'h00000000;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wdata;
    @(posedge sys_clk);
    penable <= 1'b1;
    // Wait bounded for the answer, take data at that edge only
    for (n = 0; n < 16 && !ok; n++)
    begin
      @(posedge sys_clk);
      if (pready === 1'b1)
      begin
        ok = 1'b1;
        rdata = prdata;
        err = pslverr;
      end
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule // apb_host_model
`default_nettype wire

// ---- testbench.sv ----
// Self-checking testbench for the cam track signal path
`default_nettype none
module testbench
  import cam_track_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [POS_W-1:0] actual_position = '0;
  logic brake_enable_input = 1'b0;
  logic track3_gate_input = 1'b0;
  logic [NUM_OUT-1:0] track_output_pins;
  logic [NUM_TRACKS-1:0] track_signals;
  int n_errors = 0;
  int n_checks = 0;
  // 100 MHz clock
  always #5 sys_clk = ~sys_clk;
  // Design under test
  cam_track_signal_path uut (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .actual_position(actual_position), .brake_enable_input(brake_enable_input),
    .track3_gate_input(track3_gate_input), .track_output_pins(track_output_pins),
    .track_signals(track_signals));
  // Host side of the register bus
  apb_host_model host (.sys_clk(sys_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  // Verdict and end of run
  task automatic finish_test();
    if (n_errors == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Compare and count
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Bus answer missing ends the run
  task automatic bus_ok(input logic ok);
    if (ok !== 1'b1)
    begin
      n_errors++;
      $display("Error bus_answer expected 1 seen 0");
      finish_test();
    end
  endtask
  // Register write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e, ok;
    host.xfer(1'b1, a, d, r, e, ok);
    bus_ok(ok);
    chk("write_err", 32'h0, {31'h0, e});
  endtask
  // Register read with expected data and error flag
  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp, input logic eerr);
    logic [31:0] r;
    logic e, ok;
    host.xfer(1'b0, a, 32'h0, r, e, ok);
    bus_ok(ok);
    chk(name, exp, r);
    chk("read_err", {31'h0, eerr}, {31'h0, e});
  endtask
  // Move the axis and let pin syncs settle
  task automatic pos(input logic [POS_W-1:0] p);
    @(posedge sys_clk);
    actual_position <= p;
    repeat (5) @(posedge sys_clk);
  endtask
  // Enabled cam word for a track and an inclusive window
  function automatic logic [31:0] cam(input logic [4:0] t, input logic [11:0] s, input logic [11:0] e);
    return {1'b1, 2'b00, t, e, s};
  endfunction
  // Main sequence
  initial
  begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    chk("pins_rst", 32'h0, {19'h0, track_output_pins});
    chk("sig_rst", 32'h0, track_signals);
    rd_chk("ctrl_rst", OFF_CTRL, 32'h0, 1'b0);
    rd_chk("preset_rst", OFF_PRESET_A, 32'h0, 1'b0);
    rd_chk("unmapped", 8'h24, 32'h0, 1'b1);
    // Plain tracks: one low track with an output, one high track
    wr(OFF_CAM_BASE, cam(5'd5, 12'd100, 12'd104));
    wr(OFF_CAM_BASE + 8'h04, cam(5'd20, 12'd102, 12'd110));
    wr(OFF_TRACK_EN, 32'h1fff);
    pos(12'd100);
    chk("sig_100", 32'h20, track_signals);
    chk("pins_100", 32'h20, {19'h0, track_output_pins});
    pos(12'd104);
    chk("sig_104", 32'h100020, track_signals);
    pos(12'd105);
    chk("sig_105", 32'h100000, track_signals);
    chk("pins_105", 32'h0, {19'h0, track_output_pins});
    // Track enable off hides the pin but not track 20
    pos(12'd102);
    wr(OFF_TRACK_EN, 32'h1fdf);
    repeat (3) @(posedge sys_clk);
    chk("pins_dis", 32'h0, {19'h0, track_output_pins});
    chk("sig_dis", 32'h100000, track_signals);
    // Snapshots show flags before enables
    wr(OFF_READOUT, 32'h1);
    rd_chk("flag_snap", OFF_FLAG_SNAP, 32'h100020, 1'b0);
    rd_chk("pos_snap", OFF_POS_SNAP, 32'h66, 1'b0);
    wr(OFF_READOUT, 32'h2);
    rd_chk("cam_snap", OFF_CAM_SNAP, 32'h3, 1'b0);
    rd_chk("readout_rd", OFF_READOUT, 32'h0, 1'b0);
    // Direct set from the enable word, then track 3 gating
    wr(OFF_CTRL, 32'h1);
    wr(OFF_TRACK_EN, 32'h0a5a);
    pos(12'd0);
    chk("pins_direct", 32'h0a5a, {19'h0, track_output_pins});
    wr(OFF_CTRL, 32'h11);
    repeat (5) @(posedge sys_clk);
    chk("pins_gate0", 32'h0a52, {19'h0, track_output_pins});
    track3_gate_input <= 1'b1;
    repeat (5) @(posedge sys_clk);
    chk("pins_gate1", 32'h0a5a, {19'h0, track_output_pins});
    // Option off: a low gate input must not mask track 3
    wr(OFF_CTRL, 32'h01);
    track3_gate_input <= 1'b0;
    repeat (5) @(posedge sys_clk);
    chk("pins_nogate", 32'h0a5a, {19'h0, track_output_pins});
    // Counter tracks: preset 2 on track 0, preset 1 on track 1
    wr(OFF_CTRL, 32'h0);
    wr(OFF_TRACK_EN, 32'h1fff);
    wr(OFF_CAM_BASE + 8'h08, cam(5'd0, 12'd300, 12'd310));
    wr(OFF_CAM_BASE + 8'h10, cam(5'd1, 12'd300, 12'd310));
    wr(OFF_PRESET_A, 32'h2);
    wr(OFF_PRESET_B, 32'h1);
    wr(OFF_CTRL, 32'h66);
    for (int i = 0; i < 3; i++)
    begin
      pos(12'd305);
      chk("pins_cnt_in", (i == 1) ? 32'h3 : 32'h2, {19'h0, track_output_pins});
      pos(12'd320);
      chk("pins_cnt_out", 32'h0, {19'h0, track_output_pins});
    end
    // Counter mode with counting stopped keeps both flags low
    wr(OFF_CTRL, 32'h06);
    pos(12'd305);
    chk("pins_cnt_off", 32'h0, {19'h0, track_output_pins});
    pos(12'd320);
    // Brake track: set on input rise, clear after input low and a result fall
    wr(OFF_CTRL, 32'h08);
    wr(OFF_CAM_BASE + 8'h0c, cam(5'd2, 12'd400, 12'd410));
    pos(12'd405);
    chk("pins_brk_none", 32'h0, {19'h0, track_output_pins});
    brake_enable_input <= 1'b1;
    repeat (5) @(posedge sys_clk);
    chk("pins_brk_set", 32'h4, {19'h0, track_output_pins});
    pos(12'd420);
    chk("pins_brk_hold", 32'h4, {19'h0, track_output_pins});
    pos(12'd405);
    brake_enable_input <= 1'b0;
    repeat (5) @(posedge sys_clk);
    chk("pins_brk_low", 32'h4, {19'h0, track_output_pins});
    pos(12'd420);
    chk("pins_brk_clr", 32'h0, {19'h0, track_output_pins});
    finish_test();
  end
endmodule // testbench
`default_nettype wire
